// ### src/lcd_bias_seq_pkg.sv
// constants, state type and timing figures of the bias rail sequencer

package lcd_bias_seq_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int NS_PER_MS = 1000000;
	localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
	localparam int SOFT_START_MS = 50;
	localparam int SHUTDOWN_MS = 50;
	localparam int SETPOINT_MS = 50;
	localparam int RESTART_MS = 100;
	localparam int CLEAR_NS = 1000;
	// least time, so rounded up
	localparam int CLEAR_CYCLES = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_LIMIT = 8;
	// internal oscillator half period in cycles (1 MHz)
	localparam int OSC_HALF_CYCLES = 25;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int DIV_W = 17;
	localparam int MS_W = 7;
	localparam int FCNT_W = 4;
	localparam int CLR_W = 7;
	localparam int SYNC_W = 10;

	typedef enum logic [3:0] {
		ST_SLEEP, ST_OFF, ST_LOGIC, ST_ANALOG, ST_NEG, ST_POS, ST_SETPT,
		ST_COM, ST_RUN, ST_SD_RAILS, ST_SD_NEG, ST_RETRY, ST_LOCKED
	} seq_state_type;

endpackage : lcd_bias_seq_pkg

// ### src/lcd_bias_rail_sequencer.sv
// power-up and power-down sequencer for five display bias rails
`timescale 1ns/100ps
`default_nettype none

module lcd_bias_rail_sequencer
	import lcd_bias_seq_pkg::*;
#(
	parameter int MS_CYCLES = CYCLES_PER_MS
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic input_supply_ok,
	input wire logic first_enable,
	input wire logic second_enable,
	input wire logic logic_supply_good,
	input wire logic analog_supply_good,
	input wire logic negative_gate_good,
	input wire logic negative_gate_low30,
	input wire logic positive_gate_good,
	input wire logic positive_gate_low10,
	input wire logic common_rail_good,
	input wire logic common_setpoint_valid,
	input wire logic analog_dropout_low,
	input wire logic sync_present,
	input wire logic sync_in,
	output logic asleep,
	output logic logic_supply_en,
	output logic analog_supply_en,
	output logic negative_gate_en,
	output logic positive_gate_en,
	output logic common_rail_en,
	output logic pulldown_analog,
	output logic pulldown_negative,
	output logic pulldown_positive,
	output logic pulldown_common,
	output logic boost_raise_req,
	output logic pump_clk,
	output logic fault,
	output logic [FCNT_W-1:0] fault_count
);

	// ************************************************************
	// state and timers
	// ************************************************************
	seq_state_type state_q, state_d;
	logic [DIV_W-1:0] div_q;
	logic [MS_W-1:0] ms_q;
	logic [CLR_W-1:0] clr_q;
	logic [SYNC_W-1:0] sy_cnt_q, sy_per_q, osc_q;
	logic sync_prev_q;

	// time limit that applies in each state
	function automatic logic [MS_W-1:0] state_limit(seq_state_type s);
		case (s)
			ST_SETPT: state_limit = MS_W'(SETPOINT_MS);
			ST_SD_RAILS, ST_SD_NEG: state_limit = MS_W'(SHUTDOWN_MS);
			ST_RETRY: state_limit = MS_W'(RESTART_MS);
			default: state_limit = MS_W'(SOFT_START_MS);
		endcase
	endfunction : state_limit

	// timer restarts on every state change so each wait is measured alone
	wire timer_clr = (state_d != state_q);
	wire ms_tick = (div_q == DIV_W'(MS_CYCLES - 1));
	wire timeout = (ms_q >= state_limit(state_q));
	wire clr_done = (clr_q == CLR_W'(CLEAR_CYCLES));
	wire retry_left = (fault_count < FCNT_W'(RETRY_LIMIT));

	// soft-start and setpoint waits that run out are faults
	wire ss_fail = timeout && (
		(state_q == ST_LOGIC && !logic_supply_good) ||
		state_q == ST_ANALOG || state_q == ST_NEG ||
		state_q == ST_POS || state_q == ST_COM ||
		state_q == ST_SETPT);
	wire fault_inc = ss_fail && state_d == ST_RETRY;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_SLEEP: state_d = ST_OFF;
			ST_OFF: begin
				if (first_enable) state_d = ST_LOGIC;
			end
			ST_LOGIC: begin
				if (!first_enable) state_d = ST_OFF;
				else if (second_enable && logic_supply_good)
					state_d = ST_ANALOG;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_ANALOG: begin
				if (analog_supply_good) state_d = ST_NEG;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_NEG: begin
				if (negative_gate_good) state_d = ST_POS;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_POS: begin
				if (positive_gate_good)
					state_d = common_setpoint_valid ? ST_COM : ST_SETPT;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_SETPT: begin
				if (common_setpoint_valid) state_d = ST_COM;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_COM: begin
				if (common_rail_good) state_d = ST_RUN;
				else if (ss_fail) state_d = ST_RETRY;
			end
			ST_RUN: state_d = ST_RUN;
			ST_SD_RAILS: begin
				// analog and common rails never block: bypassed
				if (positive_gate_low10 || timeout)
					state_d = ST_SD_NEG;
			end
			ST_SD_NEG: begin
				if (negative_gate_low30 || timeout)
					state_d = first_enable ? ST_LOGIC : ST_OFF;
			end
			ST_RETRY: begin
				if (clr_done) state_d = ST_OFF;
				else if (timeout)
					state_d = !retry_left ? ST_LOCKED :
						(first_enable ? ST_LOGIC : ST_OFF);
			end
			ST_LOCKED: begin
				if (clr_done) state_d = ST_OFF;
			end
			default: state_d = ST_SLEEP;
		endcase
		// second enable low starts the rail shutdown from any state from ST_ANALOG through ST_RUN;
		// first enable is not looked at here, so an early drop is held off
		if ((state_q == ST_ANALOG || state_q == ST_NEG ||
			state_q == ST_POS || state_q == ST_SETPT ||
			state_q == ST_COM || state_q == ST_RUN) && !second_enable)
			state_d = ST_SD_RAILS;
		if (!input_supply_ok) state_d = ST_SLEEP;
	end

	// ************************************************************
	// output decode from the next state
	// ************************************************************
	wire logic_en_d = (state_d >= ST_LOGIC && state_d <= ST_SD_NEG);
	wire analog_en_d = (state_d >= ST_ANALOG && state_d <= ST_RUN) &&
		first_enable && second_enable;
	wire neg_en_d = (state_d >= ST_NEG && state_d <= ST_SD_RAILS);
	wire pos_en_d = (state_d >= ST_POS && state_d <= ST_RUN);
	wire com_en_d = (state_d == ST_COM || state_d == ST_RUN);
	// pull-downs held from first enable until full shutdown
	wire pd_zone_d = (state_d >= ST_LOGIC);

	// ************************************************************
	// pump clock: sync regenerated or internal oscillator
	// ************************************************************
	wire sync_rise = sync_in && !sync_prev_q;
	wire sync_phase = (sy_cnt_q < (sy_per_q >> 1));
	wire osc_phase = (osc_q < SYNC_W'(OSC_HALF_CYCLES));
	wire osc_wrap = (osc_q == SYNC_W'(2 * OSC_HALF_CYCLES - 1));
	wire pump_run = neg_en_d || pos_en_d;
	wire pump_clk_d = pump_run && (sync_present ? sync_phase : osc_phase);

	// ************************************************************
	// registers
	// ************************************************************
	// state and enables
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			state_q <= ST_SLEEP;
			asleep <= 1'b1;
			logic_supply_en <= 1'b0;
			analog_supply_en <= 1'b0;
			negative_gate_en <= 1'b0;
			positive_gate_en <= 1'b0;
			common_rail_en <= 1'b0;
		end else begin
			state_q <= state_d;
			asleep <= (state_d == ST_SLEEP);
			logic_supply_en <= logic_en_d;
			analog_supply_en <= analog_en_d;
			negative_gate_en <= neg_en_d;
			positive_gate_en <= pos_en_d;
			common_rail_en <= com_en_d;
		end
	end

	// pull-downs drop on the same edge the rail enables
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pulldown_analog <= 1'b0;
			pulldown_negative <= 1'b0;
			pulldown_positive <= 1'b0;
			pulldown_common <= 1'b0;
			boost_raise_req <= 1'b0;
		end else begin
			pulldown_analog <= pd_zone_d && !analog_en_d;
			pulldown_negative <= pd_zone_d && !neg_en_d;
			pulldown_positive <= pd_zone_d && !pos_en_d;
			pulldown_common <= pd_zone_d && !com_en_d;
			boost_raise_req <= analog_en_d && analog_dropout_low;
		end
	end

	// millisecond divider and wait counter, saturating
	always_ff @(posedge core_clk) begin
		if (!reset_n || timer_clr) begin
			div_q <= '0;
			ms_q <= '0;
		end else begin
			div_q <= ms_tick ? '0 : div_q + 1'b1;
			if (ms_tick && ms_q != '1) ms_q <= ms_q + 1'b1;
		end
	end

	// fault counter; an increment wins over the clear
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			clr_q <= '0;
			fault_count <= '0;
			fault <= 1'b0;
		end else begin
			if (first_enable) clr_q <= '0;
			else if (!clr_done) clr_q <= clr_q + 1'b1;
			if (fault_inc) begin
				fault_count <= fault_count + 1'b1;
				fault <= 1'b1;
			end else if (clr_done) begin
				fault_count <= '0;
				fault <= 1'b0;
			end
		end
	end

	// sync period measurement, oscillator and pump clock
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			sync_prev_q <= 1'b0;
			sy_cnt_q <= '0;
			sy_per_q <= '0;
			osc_q <= '0;
			pump_clk <= 1'b0;
		end else begin
			sync_prev_q <= sync_in;
			sy_cnt_q <= sync_rise ? '0 : sy_cnt_q + 1'b1;
			if (sync_rise) sy_per_q <= sy_cnt_q + 1'b1;
			osc_q <= osc_wrap ? '0 : osc_q + 1'b1;
			pump_clk <= pump_clk_d;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_en1_start;
		state_q == ST_OFF && first_enable && input_supply_ok;
	endsequence
	sequence s_all_pulled;
		pulldown_analog && pulldown_negative &&
		pulldown_positive && pulldown_common;
	endsequence
	sequence s_neg_hold;
		state_q == ST_SD_NEG && !first_enable && !negative_gate_low30 &&
		!timeout && input_supply_ok;
	endsequence

	sleep_hold_a: assert property (
		!input_supply_ok |=> asleep && !logic_supply_en && !analog_supply_en)
		else $error("rails active below lockout");
	second_gate_a: assert property (
		$rose(analog_supply_en) |-> $past(logic_supply_good))
		else $error("analog rail started before logic supply good");
	pos_order_a: assert property (
		$rose(positive_gate_en) |-> $past(negative_gate_good) && negative_gate_en)
		else $error("positive gate before negative gate good");
	com_order_a: assert property (
		$rose(common_rail_en) |-> $past(common_setpoint_valid) && positive_gate_en)
		else $error("common rail without setpoint or positive gate");
	neg_off_a: assert property (
		state_q == ST_SD_RAILS && !positive_gate_low10 && !timeout &&
		input_supply_ok |=> negative_gate_en)
		else $error("negative gate dropped too early");
	en1_hold_a: assert property (
		s_neg_hold |=> logic_supply_en && state_q == ST_SD_NEG)
		else $error("early first enable low acted on");
	early_en1_a: assert property (
		state_q == ST_RUN && !first_enable && second_enable &&
		input_supply_ok |=> state_q == ST_RUN && negative_gate_en)
		else $error("run left while second enable high");
	pulldown_on_a: assert property (
		s_en1_start |=> s_all_pulled ##0 logic_supply_en)
		else $error("pull-downs not engaged at first enable");
	release_a: assert property (
		state_q == ST_SD_NEG && negative_gate_low30 && !first_enable &&
		input_supply_ok |=> state_q == ST_OFF && !pulldown_negative &&
		!logic_supply_en)
		else $error("shutdown did not release pull-downs");
	analog_both_a: assert property (
		analog_supply_en |-> $past(first_enable && second_enable))
		else $error("analog rail without both enables");
	headroom_a: assert property (
		analog_supply_en && analog_dropout_low && $stable(analog_supply_en)
		|=> boost_raise_req || !analog_supply_en)
		else $error("headroom request missing");
	setpoint_fault_a: assert property (
		state_q == ST_SETPT && timeout && !common_setpoint_valid &&
		second_enable && input_supply_ok |=> fault && state_q == ST_RETRY)
		else $error("setpoint wait did not fault");
	clear_cnt_a: assert property (
		clr_done && !fault_inc |=> fault_count == '0 && !fault)
		else $error("fault counter not cleared");

endmodule : lcd_bias_rail_sequencer

`default_nettype wire

// ### test/rail_model.sv
// comparator model of one bias rail answering its enable
`timescale 1ns/100ps
`default_nettype none

module rail_model (
	input wire logic core_clk,
	input wire logic en,
	input wire logic no_rise,
	input wire logic no_fall,
	input wire logic [7:0] dly,
	output logic good,
	output logic low
);
	logic en_q = 1'b0;
	logic [7:0] cnt_q = 8'hff;

	// rail starts discharged
	initial begin
		good = 1'b0;
		low = 1'b1;
	end

	// ramps dly cycles after a change; a stuck rail never crosses
	always @(negedge core_clk) begin
		en_q <= en;
		cnt_q <= (en != en_q) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
		// a fresh change restarts the ramp, so the stale count must not pass
		good <= en && en == en_q && !no_rise && cnt_q >= dly;
		low <= !en && en == en_q && !no_fall && cnt_q >= dly;
	end
endmodule : rail_model
`default_nettype wire

// ### test/lcd_bias_rail_sequencer_tb_top.sv
// self-checking bench of the bias rail sequencer
`timescale 1ns/100ps
`default_nettype none

module lcd_bias_rail_sequencer_tb_top;
	import lcd_bias_seq_pkg::*;
	localparam int MSC = 20; // short ms so the run stays brief
	logic core_clk, reset_n, input_supply_ok, first_enable, second_enable;
	logic common_setpoint_valid, analog_dropout_low, sync_present;
	logic logic_supply_good, analog_supply_good, negative_gate_good;
	logic negative_gate_low30, positive_gate_good, positive_gate_low10;
	logic common_rail_good, asleep, logic_supply_en, analog_supply_en;
	logic negative_gate_en, positive_gate_en, common_rail_en;
	logic pulldown_analog, pulldown_negative, pulldown_positive;
	logic pulldown_common, pump_clk, fault, boost_raise_req;
	logic sync_in = 1'b0;
	logic [FCNT_W-1:0] fault_count;
	logic [4:0] no_rise, no_fall, en_v;
	logic [7:0] dly [5];
	logic [7:0] mon;
	logic [3:0] pd;
	logic pos_p = 1'b0;
	logic com_p = 1'b0;
	logic neg_p = 1'b0;
	int failures, comparisons, hi, lo;
	int cyc = 0;
	int sync_half = 4;
	int sync_k = 0;

	assign en_v = {common_rail_en, positive_gate_en, negative_gate_en,
		analog_supply_en, logic_supply_en};
	assign mon = {pump_clk, asleep, fault, en_v};
	assign pd = {pulldown_analog, pulldown_negative, pulldown_positive,
		pulldown_common};

	lcd_bias_rail_sequencer #(.MS_CYCLES(MSC)) lcd_bias_rail_sequencer_inst (
		.core_clk, .reset_n, .input_supply_ok, .first_enable, .second_enable,
		.logic_supply_good, .analog_supply_good, .negative_gate_good,
		.negative_gate_low30, .positive_gate_good, .positive_gate_low10,
		.common_rail_good, .common_setpoint_valid, .analog_dropout_low,
		.sync_present, .sync_in, .asleep, .logic_supply_en, .analog_supply_en,
		.negative_gate_en, .positive_gate_en, .common_rail_en, .pulldown_analog,
		.pulldown_negative, .pulldown_positive, .pulldown_common,
		.boost_raise_req, .pump_clk, .fault, .fault_count);

	// rail comparators: logic, analog, negative, positive, common
	rail_model rail_model_logic (.core_clk, .en(en_v[0]), .no_rise(no_rise[0]),
		.no_fall(no_fall[0]), .dly(dly[0]), .good(logic_supply_good), .low());
	rail_model rail_model_analog (.core_clk, .en(en_v[1]), .no_rise(no_rise[1]),
		.no_fall(no_fall[1]), .dly(dly[1]), .good(analog_supply_good), .low());
	rail_model rail_model_neg (.core_clk, .en(en_v[2]), .no_rise(no_rise[2]),
		.no_fall(no_fall[2]), .dly(dly[2]), .good(negative_gate_good),
		.low(negative_gate_low30));
	rail_model rail_model_pos (.core_clk, .en(en_v[3]), .no_rise(no_rise[3]),
		.no_fall(no_fall[3]), .dly(dly[3]), .good(positive_gate_good),
		.low(positive_gate_low10));
	rail_model rail_model_com (.core_clk, .en(en_v[4]), .no_rise(no_rise[4]),
		.no_fall(no_fall[4]), .dly(dly[4]), .good(common_rail_good), .low());

	// ************************************************************
	// clock, sync source, hang guard
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// sync changes off the sampling edge
	always @(negedge core_clk) begin
		sync_k = (sync_k + 1) % (2 * sync_half);
		sync_in <= (sync_k < sync_half);
	end

	// bound well above the expected run of about 35k cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			$display("[ERR] run length expected end seen hang");
			end_sim();
		end
	end

	// order watch, sampled once outputs have settled after the edge
	always @(posedge core_clk) begin
		#5;
		if (positive_gate_en && !pos_p) check_bit("neg good", 1'b1, negative_gate_good);
		if (common_rail_en && !com_p) check_bit("pos good", 1'b1, positive_gate_good && common_setpoint_valid);
		if (negative_gate_en && !neg_p) check_bit("neg pulldown", 1'b0, pulldown_negative);
		if (analog_supply_en === 1'b1) check_bit("both en", 1'b1, first_enable && second_enable);
		pos_p = positive_gate_en;
		com_p = common_rail_en;
		neg_p = negative_gate_en;
	end

	task automatic check_bit(input string n, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", n, e, g);
		end
	endtask : check_bit

	task automatic check_vec(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", n, e, g);
		end
	endtask : check_vec

	// bounded wait on one watched output; a miss counts as mismatch
	task automatic wait_sig(input int i, input logic v, input int lim);
		int k;
		k = 0;
		while (mon[i] !== v && k < lim) begin
			@(negedge core_clk);
			k++;
		end
		check_bit($sformatf("output %0d", i), v, mon[i]);
	endtask : wait_sig

	task automatic measure_pump();
		wait_sig(7, 1'b0, 200);
		wait_sig(7, 1'b1, 200);
		hi = 0;
		lo = 0;
		while (pump_clk === 1'b1 && hi < 200) begin
			@(negedge core_clk);
			hi++;
		end
		while (pump_clk === 1'b0 && lo < 200) begin
			@(negedge core_clk);
			lo++;
		end
	endtask : measure_pump

	task automatic ticks(input int n);
		repeat (n) @(negedge core_clk);
	endtask : ticks

	task automatic end_sim();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		reset_n = 1'b0;
		input_supply_ok = 1'b0;
		first_enable = 1'b0;
		second_enable = 1'b0;
		common_setpoint_valid = 1'b1;
		analog_dropout_low = 1'b0;
		sync_present = 1'b0;
		no_rise = 5'h00;
		no_fall = 5'h00;
		failures = 0;
		comparisons = 0;
		void'($urandom(21));
		foreach (dly[i]) dly[i] = 8'($urandom_range(12, 2));
		sync_half = $urandom_range(10, 3);
		ticks(16);
		reset_n = 1'b1;
		check_bit("asleep", 1'b1, asleep);
		check_vec("count", 16'h0000, 16'(fault_count));
		// enables raised while still locked out
		first_enable = 1'b1;
		second_enable = 1'b1;
		ticks(20);
		check_bit("sleep", 1'b1, asleep);
		check_bit("logic en", 1'b0, logic_supply_en);
		input_supply_ok = 1'b1;
		wait_sig(0, 1'b1, 4);
		check_vec("pulldowns", 16'h000f, 16'(pd));
		check_bit("analog early", 1'b0, analog_supply_en);
		wait_sig(4, 1'b1, 200);
		analog_dropout_low = 1'b1;
		ticks(2);
		check_bit("boost req", 1'b1, boost_raise_req);
		analog_dropout_low = 1'b0;
		ticks(2);
		check_bit("boost idle", 1'b0, boost_raise_req);
		$display("test startup finished");
		measure_pump();
		check_vec("pump high", 16'(OSC_HALF_CYCLES), 16'(hi));
		check_vec("pump low", 16'(OSC_HALF_CYCLES), 16'(lo));
		sync_present = 1'b1;
		ticks(60);
		measure_pump();
		check_vec("sync high", 16'(sync_half), 16'(hi));
		check_vec("sync low", 16'(sync_half), 16'(lo));
		sync_present = 1'b0;
		$display("test pump finished");
		// first enable dropped early, positive rail stuck charged
		first_enable = 1'b0;
		ticks(20);
		check_bit("com held", 1'b1, common_rail_en);
		check_bit("neg held", 1'b1, negative_gate_en);
		no_fall[3] = 1'b1;
		second_enable = 1'b0;
		ticks(2);
		check_vec("rails", 16'h0001, 16'({analog_supply_en, positive_gate_en, common_rail_en, negative_gate_en}));
		ticks(50 * MSC - 10);
		check_bit("neg wait", 1'b1, negative_gate_en);
		wait_sig(2, 1'b0, 20);
		check_bit("bypass fault", 1'b0, fault);
		no_fall[3] = 1'b0;
		wait_sig(0, 1'b0, 50);
		check_vec("released", 16'h0000, 16'(pd));
		$display("test early shutdown finished");
		first_enable = 1'b1;
		wait_sig(0, 1'b1, 4);
		second_enable = 1'b1;
		wait_sig(4, 1'b1, 200);
		no_fall[2] = 1'b1;
		second_enable = 1'b0;
		wait_sig(2, 1'b0, 60);
		first_enable = 1'b0;
		ticks(20);
		check_bit("logic held", 1'b1, logic_supply_en);
		no_fall[2] = 1'b0;
		wait_sig(0, 1'b0, 30);
		$display("test normal shutdown finished");
		common_setpoint_valid = 1'b0;
		first_enable = 1'b1;
		wait_sig(0, 1'b1, 4);
		second_enable = 1'b1;
		wait_sig(3, 1'b1, 200);
		ticks(50 * MSC - 10);
		check_bit("setpoint wait", 1'b0, fault);
		wait_sig(5, 1'b1, 30);
		check_vec("count", 16'h0001, 16'(fault_count));
		ticks(100 * MSC - 10);
		check_bit("restart wait", 1'b0, analog_supply_en);
		wait_sig(1, 1'b1, 60);
		ticks(9 * 160 * MSC);
		check_vec("locked", 16'(RETRY_LIMIT), 16'(fault_count));
		check_bit("locked off", 1'b0, analog_supply_en);
		first_enable = 1'b0;
		second_enable = 1'b0;
		ticks(CLEAR_CYCLES - 5);
		check_vec("not cleared", 16'(RETRY_LIMIT), 16'(fault_count));
		ticks(10);
		check_vec("cleared", 16'h0000, 16'(fault_count));
		check_bit("fault clear", 1'b0, fault);
		$display("test retry finished");
		common_setpoint_valid = 1'b1;
		no_rise[1] = 1'b1;
		first_enable = 1'b1;
		wait_sig(0, 1'b1, 4);
		second_enable = 1'b1;
		wait_sig(1, 1'b1, 60);
		ticks(50 * MSC - 10);
		check_bit("soft start", 1'b0, fault);
		wait_sig(5, 1'b1, 30);
		check_vec("count", 16'h0001, 16'(fault_count));
		$display("test soft start finished");
		end_sim();
	end
endmodule : lcd_bias_rail_sequencer_tb_top
`default_nettype wire
